/* core/gain_switch_pkg.sv */
// gain switching package: gain indices, limits, defaults, codes and timing
// assumes one 125 MHz system clock and 16-bit parameter words
package gain_switch_pkg;

	// gain slots carried through the switcher
	localparam int GAIN_COUNT     = 7;
	localparam int G_SPEED        = 0;
	localparam int G_INTEGRAL     = 1;
	localparam int G_POSITION     = 2;
	localparam int G_FORCE_TC     = 3;
	localparam int G_FRICTION     = 4;
	localparam int G_MF_GAIN      = 5;
	localparam int G_MF_COMP      = 6;

	// set-two limits and defaults, slot order 6..0
	localparam logic [6:0][15:0] GAIN_MIN = {16'h01F4, 16'h000A, 16'h000A,
		16'h0000, 16'h000A, 16'h000F, 16'h000A};
	localparam logic [6:0][15:0] GAIN_MAX = {16'h07D0, 16'h4E20, 16'h03E8,
		16'hFFFF, 16'h4E20, 16'hC800, 16'h4E20};
	localparam logic [6:0][15:0] GAIN_DEF = {16'h03E8, 16'h01F4, 16'h0064,
		16'h0064, 16'h0190, 16'h07D0, 16'h0190};

	// selector digit codes
	localparam logic [3:0] MODE_MANUAL   = 4'h0;
	localparam logic [3:0] MODE_AUTO_ONE = 4'h2;
	localparam logic [3:0] COND_DONE_ON  = 4'h0;
	localparam logic [3:0] COND_DONE_OFF = 4'h1;
	localparam logic [3:0] COND_NEAR_ON  = 4'h2;
	localparam logic [3:0] COND_NEAR_OFF = 4'h3;
	localparam logic [3:0] COND_IDLE_REF = 4'h4;
	localparam logic [3:0] COND_REF_ON   = 4'h5;
	localparam logic [3:0] NOTCH_ON      = 4'h1;
	localparam int         DIGIT_MODE    = 0;
	localparam int         DIGIT_COND    = 1;
	localparam int         DIGIT_NOTCH1  = 0;
	localparam int         DIGIT_NOTCH2  = 2;

	// timebase
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_TIME_NS  = 1000000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

	// switching states, one-hot
	typedef enum logic [5:0] {
		SET_ONE   = 6'b00_0001,
		WAIT_TWO  = 6'b00_0010,
		RAMP_TWO  = 6'b00_0100,
		SET_TWO   = 6'b00_1000,
		WAIT_ONE  = 6'b01_0000,
		RAMP_ONE  = 6'b10_0000
	} switch_state_t;

endpackage : gain_switch_pkg

/* core/gain_blend.sv */
// linear blend of one gain between its old and new value
// assumes num never exceeds den; a zero den gives the new value at once
module gain_blend
	import gain_switch_pkg::*;
(
	input  wire logic [15:0] from_value,
	input  wire logic [15:0] to_value,
	input  wire logic [15:0] num,
	input  wire logic [15:0] den,
	output logic      [15:0] blended
);

	logic signed [16:0] delta;
	logic signed [33:0] scaled;
	logic signed [33:0] step;

	// from + (to - from) * num / den
	always_comb
	begin
		delta  = $signed({1'b0, to_value}) - $signed({1'b0, from_value});
		scaled = 34'(delta) * $signed({18'h0_0000, num});
		step   = (den == 16'h0000) ? 34'(delta)
			: scaled / $signed({18'h0_0000, den});
		blended = 16'($signed({18'h0_0000, from_value}) + step);
	end

endmodule : gain_blend

/* core/servo_gain_set_switcher.sv */
// servo gain set switcher: picks gain set one or two, ramps between them
// assumes parameter words arrive on ref_clk; status pins are asynchronous
// Contract
// - lowest selector digit 0 is manual, 2 is automatic pattern one.
// - set-two speed gain 10..20000, integral time 15..51200.
// - set-two position gain accepted from 10 to 20000.
// - set-two model follow gain 10..20000, compensation 500..2000.
// - set-two force filter time constant 0..65535.
// - set-two friction compensation gain accepted from 10 to 1000.
// - two ramp times, one per direction, in milliseconds.
// - two waiting times, one per direction, in milliseconds.
// - second selector digit picks condition A under position control.
// - outside position control the set is fixed by the condition code.
// - lag filter and notch stages sit in series, each independent.
// - each notch stage is enabled or bypassed by its config digit.
// - manual mode: gain select high gives set one, low gives set two.
// - after condition A changes, wait then ramp linearly to new gains.
// - model follow gains switch manually, only idle and fully stopped.
module servo_gain_set_switcher
	import gain_switch_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [15:0]      gain_switch_selector,
	input  wire logic [6:0][15:0] gain_set_one,
	input  wire logic [15:0]      speed_gain_set_two,
	input  wire logic [15:0]      speed_integral_set_two,
	input  wire logic [15:0]      position_gain_set_two,
	input  wire logic [15:0]      model_follow_gain_set_two,
	input  wire logic [15:0]      model_follow_comp_set_two,
	input  wire logic [15:0]      force_filter_tc_set_two,
	input  wire logic [15:0]      friction_comp_gain_set_two,
	input  wire logic [15:0]      ramp_time_to_set_two,
	input  wire logic [15:0]      ramp_time_to_set_one,
	input  wire logic [15:0]      wait_time_to_set_two,
	input  wire logic [15:0]      wait_time_to_set_one,
	input  wire logic [15:0]      filter_enable_config,
	input  wire logic             position_control,
	input  wire logic             positioning_done,
	input  wire logic             near_position,
	input  wire logic             pos_filter_idle,
	input  wire logic             ref_input_on,
	input  wire logic             gain_select_input_b,
	input  wire logic             command_busy,
	input  wire logic             motor_stopped,
	output logic      [6:0][15:0] active_gain,
	output logic                  set_two_active,
	output logic                  lag_filter_enable,
	output logic                  notch_one_enable,
	output logic                  notch_two_enable
);

	typedef struct packed {
		switch_state_t    st;
		logic [16:0]      div;
		logic [15:0]      elapsed;
		logic [3:0]       pin_meta;
		logic [3:0]       pin_sync;
		logic             mf_two;
		logic [6:0][15:0] gain;
		logic             notch1;
		logic             notch2;
	} regs_t;

	regs_t            r;
	regs_t            next_r;
	logic             tick;
	logic             sel_active;
	logic             cond_a;
	logic             toward_two;
	logic             ramping;
	logic [15:0]      num;
	logic [15:0]      den;
	logic [3:0]       mode;
	logic [3:0]       cond_code;
	logic [6:0][15:0] set_two;
	logic [6:0][15:0] blended;

	// one hex digit of a 16-bit setting word
	function automatic logic [3:0] digit(input logic [15:0] w, input int i);
		digit = w[i*4 +: 4];
	endfunction : digit

	// limit a set-two value to its accepted range
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input int g);
		clamp = (v < GAIN_MIN[g]) ? GAIN_MIN[g]
			: (v > GAIN_MAX[g]) ? GAIN_MAX[g] : v;
	endfunction : clamp

	// synchronised status pins, one bit each
	assign sel_active = ~r.pin_sync[0];
	assign mode       = digit(gain_switch_selector, DIGIT_MODE);
	assign cond_code  = digit(gain_switch_selector, DIGIT_COND);

	// set-two values limited, slot order as in the package
	// range limits
	assign set_two[G_SPEED]    = clamp(speed_gain_set_two, G_SPEED);
	assign set_two[G_INTEGRAL] = clamp(speed_integral_set_two, G_INTEGRAL);
	assign set_two[G_POSITION] = clamp(position_gain_set_two, G_POSITION);
	assign set_two[G_FORCE_TC] = clamp(force_filter_tc_set_two, G_FORCE_TC);
	assign set_two[G_FRICTION] = clamp(friction_comp_gain_set_two,
		G_FRICTION);
	assign set_two[G_MF_GAIN]  = clamp(model_follow_gain_set_two, G_MF_GAIN);
	assign set_two[G_MF_COMP]  = clamp(model_follow_comp_set_two, G_MF_COMP);

	// millisecond tick from the divider
	// millisecond timebase
	assign tick = (r.div == 17'h0_0000);

	// condition A decode
	// condition A select
	always_comb
	begin
		case (cond_code)
			COND_DONE_ON:  cond_a = r.pin_sync[1];
			COND_DONE_OFF: cond_a = ~r.pin_sync[1];
			COND_NEAR_ON:  cond_a = r.pin_sync[2];
			COND_NEAR_OFF: cond_a = ~r.pin_sync[2];
			COND_IDLE_REF: cond_a = r.pin_sync[3] & ~ref_input_on;
			COND_REF_ON:   cond_a = ref_input_on;
			default:       cond_a = 1'b0;
		endcase
	end

	// blend weights: settled states use weight one
	assign ramping    = (r.st == RAMP_TWO) | (r.st == RAMP_ONE);
	assign toward_two = (r.st == RAMP_TWO) | (r.st == SET_TWO)
		| (r.st == WAIT_ONE);
	assign num = ramping ? r.elapsed : 16'h0001;
	assign den = (r.st == RAMP_TWO) ? ramp_time_to_set_two
		: (r.st == RAMP_ONE) ? ramp_time_to_set_one : 16'h0001;

	// one blender per gain slot
	// linear ramp per gain
	genvar g;
	generate
		for (g = 0; g < GAIN_COUNT; g++)
		begin : g_blend
			gain_blend u_blend (
				.from_value (toward_two ? gain_set_one[g] : set_two[g]),
				.to_value   (toward_two ? set_two[g] : gain_set_one[g]),
				.num        (num),
				.den        (den),
				.blended    (blended[g])
			);
		end
	endgenerate

	// next-state logic
	always_comb
	begin
		next_r          = r;
		next_r.pin_meta = {pos_filter_idle, near_position,
			positioning_done, gain_select_input_b};
		next_r.pin_sync = r.pin_meta;
		next_r.div = tick ? 17'(TICK_COUNT - 1) : r.div - 17'h0_0001;
		if (mode != MODE_AUTO_ONE)
		begin
			next_r.st      = sel_active ? SET_TWO : SET_ONE;
			next_r.elapsed = 16'h0000;
		end
		else if (!position_control)
		begin
			next_r.st      = cond_code[0] ? SET_TWO : SET_ONE;
			next_r.elapsed = 16'h0000;
		end
		else
		begin
			case (r.st)
				SET_ONE:
					if (cond_a)
					begin
						next_r.st      = WAIT_TWO;
						next_r.elapsed = 16'h0000;
					end
				WAIT_TWO:
					if (!cond_a)
						next_r.st = SET_ONE;
					else if (tick && r.elapsed >= wait_time_to_set_two)
					begin
						next_r.st      = RAMP_TWO;
						next_r.elapsed = 16'h0000;
					end
					else if (tick)
						next_r.elapsed = r.elapsed + 16'h0001;
				RAMP_TWO:
					if (tick && 17'(r.elapsed) + 17'h0_0001
						>= 17'(ramp_time_to_set_two))
						next_r.st = SET_TWO;
					else if (tick)
						next_r.elapsed = r.elapsed + 16'h0001;
				SET_TWO:
					if (!cond_a)
					begin
						next_r.st      = WAIT_ONE;
						next_r.elapsed = 16'h0000;
					end
				WAIT_ONE:
					if (cond_a)
						next_r.st = SET_TWO;
					else if (tick && r.elapsed >= wait_time_to_set_one)
					begin
						next_r.st      = RAMP_ONE;
						next_r.elapsed = 16'h0000;
					end
					else if (tick)
						next_r.elapsed = r.elapsed + 16'h0001;
				RAMP_ONE:
					if (tick && 17'(r.elapsed) + 17'h0_0001
						>= 17'(ramp_time_to_set_one))
						next_r.st = SET_ONE;
					else if (tick)
						next_r.elapsed = r.elapsed + 16'h0001;
				default:
					next_r.st = SET_ONE;
			endcase
		end
		if (mode == MODE_MANUAL && !command_busy && motor_stopped)
			next_r.mf_two = sel_active;
		next_r.gain = blended;
		next_r.gain[G_MF_GAIN] = r.mf_two ? set_two[G_MF_GAIN]
			: gain_set_one[G_MF_GAIN];
		next_r.gain[G_MF_COMP] = r.mf_two ? set_two[G_MF_COMP]
			: gain_set_one[G_MF_COMP];
		next_r.notch1 = digit(filter_enable_config, DIGIT_NOTCH1) == NOTCH_ON;
		next_r.notch2 = digit(filter_enable_config, DIGIT_NOTCH2) == NOTCH_ON;
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r.st       <= SET_ONE;
			r.div      <= 17'h0_0000;
			r.elapsed  <= 16'h0000;
			r.pin_meta <= 4'h1;
			r.pin_sync <= 4'h1;
			r.mf_two   <= 1'b0;
			r.gain     <= GAIN_DEF;
			r.notch1   <= 1'b0;
			r.notch2   <= 1'b0;
		end
		else
			r <= next_r;
	end

	// outputs; lag stage always in path, notches independently bypassed
	// series filter stages
	assign active_gain       = r.gain;
	assign set_two_active    = toward_two;
	assign lag_filter_enable = 1'b1;
	assign notch_one_enable  = r.notch1;
	assign notch_two_enable  = r.notch2;

	mode_manual_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode == MODE_MANUAL && sel_active) |=> (r.st == SET_TWO))
		else $error("manual select did not give set two");
	speed_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.st == SET_TWO) ##1 (r.st == SET_TWO)
		|-> r.gain[G_SPEED] >= 16'h000A && r.gain[G_SPEED] <= 16'h4E20)
		else $error("speed gain out of range");
	pos_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.st == SET_TWO) |=> (r.st != SET_TWO)
		|| r.gain[G_POSITION] == $past(set_two[G_POSITION]))
		else $error("position gain not set two value");
	fric_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.st == SET_TWO) |=> (r.st != SET_TWO)
		|| r.gain[G_FRICTION] <= 16'h03E8)
		else $error("friction gain above limit");
	fixed_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mode == MODE_AUTO_ONE && !position_control && cond_code == 4'h3)
		|=> (r.st == SET_TWO))
		else $error("odd code outside position did not fix set two");
	wait_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.st == WAIT_TWO) |=>
		r.gain[G_POSITION] == $past(gain_set_one[G_POSITION]))
		else $error("gain moved during wait");
	mf_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(command_busy || mode != MODE_MANUAL) |=> $stable(r.mf_two))
		else $error("model follow switched while busy or automatic");
	tick_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		tick |=> !tick)
		else $error("tick lasted two cycles");
	notch_en_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 notch_two_enable == ($past(filter_enable_config[11:8]) == 4'h1))
		else $error("notch two enable wrong");

endmodule : servo_gain_set_switcher

/* dv/status_pin_model.sv */
// status pin model: positioning, near, filter idle and gain select pins
// assumes the bench asks for levels; pins move just after a clock edge
module status_pin_model
(
	input  wire logic       ref_clk,
	input  wire logic [3:0] want,
	output logic            positioning_done,
	output logic            near_position,
	output logic            pos_filter_idle,
	output logic            gain_select_input_b
);
	timeunit 1ns;
	timeprecision 1ps;

	// status pin levels
	// pins are unsynchronised, so they move off the edge
	// one driver only: pins settle 2 ns after the first edge, in reset
	always @(posedge ref_clk)
	begin
		#2;
		{gain_select_input_b, pos_filter_idle, near_position,
			positioning_done} = want;
	end
endmodule : status_pin_model

/* dv/servo_gain_set_switcher_test.sv */
// bench for the gain set switcher: manual, automatic, fixed sets, filters
// assumes a 10-cycle tick and the pin model beside the block
module servo_gain_set_switcher_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic             ref_clk;
	logic             rst_b;
	logic             pc;
	logic             ref_on;
	logic             busy;
	logic             stopped;
	logic             two;
	logic             lag;
	logic             n1;
	logic             n2;
	logic             done_p;
	logic             near_p;
	logic             idle_p;
	logic             gsel_b;
	logic [3:0]       want;
	logic [15:0]      sel;
	logic [15:0]      fcfg;
	logic [3:0][15:0] tm;
	logic [6:0][15:0] g1;
	logic [6:0][15:0] g2;
	logic [6:0][15:0] gain;
	int               failures = 0;
	int               n_compared = 0;

	servo_gain_set_switcher #(.TICK_COUNT(10)) uut
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.gain_switch_selector(sel),
		.gain_set_one(g1),
		.speed_gain_set_two(g2[0]),
		.speed_integral_set_two(g2[1]),
		.position_gain_set_two(g2[2]),
		.force_filter_tc_set_two(g2[3]),
		.friction_comp_gain_set_two(g2[4]),
		.model_follow_gain_set_two(g2[5]),
		.model_follow_comp_set_two(g2[6]),
		.ramp_time_to_set_two(tm[0]),
		.ramp_time_to_set_one(tm[1]),
		.wait_time_to_set_two(tm[2]),
		.wait_time_to_set_one(tm[3]),
		.filter_enable_config(fcfg),
		.position_control(pc),
		.positioning_done(done_p),
		.near_position(near_p),
		.pos_filter_idle(idle_p),
		.ref_input_on(ref_on),
		.gain_select_input_b(gsel_b),
		.command_busy(busy),
		.motor_stopped(stopped),
		.active_gain(gain),
		.set_two_active(two),
		.lag_filter_enable(lag),
		.notch_one_enable(n1),
		.notch_two_enable(n2)
	);

	status_pin_model pins
	(
		.ref_clk(ref_clk),
		.want(want),
		.positioning_done(done_p),
		.near_position(near_p),
		.pos_filter_idle(idle_p),
		.gain_select_input_b(gsel_b)
	);

	// 125 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// wait n edges, then settle to the falling edge for sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : cyc

	task automatic check_set(input logic [6:0][15:0] exp);
		for (int i = 0; i < 7; i++)
			check(gain[i], exp[i]);
	endtask : check_set

	// condition pins
	// drive the pins that make condition code c true or false
	task automatic set_cond(input int c, input logic t);
		@(posedge ref_clk);
		want <= {1'b1, c == 4 && t, c == 2 ? t : c == 3 ? !t : 1'b0,
			c == 0 ? t : c == 1 ? !t : 1'b0};
		ref_on <= c == 4 ? !t : c == 5 ? t : 1'b0;
	endtask : set_cond

	// count falling edges until gain slot s matches (or leaves) v
	task automatic wait_gain(input int s, input logic [15:0] v,
		input logic eq, output int n);
		n = 0;
		while (((gain[s] === v) != eq) && n < 300)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_gain

	task automatic t_reset();
		cyc(4);
		check_set({16'h03E8, 16'h01F4, 16'h0064, 16'h0064, 16'h0190,
			16'h07D0, 16'h0190});
		check(two, 1'b0);
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
	endtask : t_reset

	task automatic t_filter();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			fcfg <= {7'h00, i[1], 7'h00, i[0]};
			cyc(2);
			check(n1, i[0]);
			check(n2, i[1]);
			check(lag, 1'b1);
		end
	endtask : t_filter

	task automatic t_manual();
		@(posedge ref_clk);
		want <= 4'h0;
		cyc(8);
		check_set(g2);
		@(posedge ref_clk);
		g2[2] <= 16'h0321;
		cyc(2);
		check(gain[2], 16'h0321);
		@(posedge ref_clk);
		busy <= 1'b1;
		want <= 4'h8;
		cyc(8);
		check(gain[0], g1[0]);
		check(gain[5], g2[5]);
		@(posedge ref_clk);
		busy <= 1'b0;
		stopped <= 1'b0;
		cyc(8);
		check(gain[6], g2[6]);
		@(posedge ref_clk);
		stopped <= 1'b1;
		cyc(2);
		check_set(g1);
	endtask : t_manual

	// out-of-range set-two values land on the limits
	task automatic t_clamp();
		@(posedge ref_clk);
		want <= 4'h0;
		g2[0] <= 16'h0005;
		g2[1] <= 16'hC801;
		g2[4] <= 16'h07D0;
		g2[6] <= 16'h0100;
		cyc(8);
		check(gain[0], 16'h000A);
		check(gain[1], 16'hC800);
		check(gain[4], 16'h03E8);
		check(gain[6], 16'h01F4);
		@(posedge ref_clk);
		want <= 4'h8;
		g2 <= {16'h0206, 16'h0205, 16'h0204, 16'h0203, 16'h0202,
			16'h0201, 16'h0200};
	endtask : t_clamp

	task automatic t_cond();
		@(posedge ref_clk);
		pc <= 1'b1;
		tm <= '0;
		for (int c = 0; c < 6; c++)
		begin
			@(posedge ref_clk);
			sel <= {8'h00, 4'(c), 4'h2};
			set_cond(c, 1'b0);
			cyc(40);
			check(two, 1'b0);
			set_cond(c, 1'b1);
			cyc(40);
			check(gain[2], g2[2]);
			set_cond(c, 1'b0);
			cyc(40);
			check(gain[2], g1[2]);
		end
	endtask : t_cond

	task automatic t_outside();
		@(posedge ref_clk);
		pc <= 1'b0;
		for (int c = 0; c < 6; c++)
		begin
			@(posedge ref_clk);
			sel <= {8'h00, 4'(c), 4'h2};
			set_cond(c, 1'b1);
			cyc(4);
			check(two, c[0]);
			check(gain[0], c[0] ? g2[0] : g1[0]);
		end
	endtask : t_outside

	task automatic t_ramp();
		int n;
		@(posedge ref_clk);
		pc <= 1'b1;
		sel <= 16'h0002;
		tm <= {16'h0001, 16'h0002, 16'h0002, 16'h0004};
		set_cond(0, 1'b0);
		cyc(80);
		check(gain[2], g1[2]);
		set_cond(0, 1'b1);
		wait_gain(2, g1[2], 1'b0, n);
		check(n >= 20 && n <= 50, 1'b1);
		check(gain[2] > g1[2] && gain[2] < g2[2], 1'b1);
		wait_gain(2, g2[2], 1'b1, n);
		check(n >= 25 && n <= 45, 1'b1);
		set_cond(0, 1'b0);
		wait_gain(2, g2[2], 1'b0, n);
		check(n >= 10 && n <= 40, 1'b1);
		check(gain[2] > g1[2] && gain[2] < g2[2], 1'b1);
		wait_gain(2, g1[2], 1'b1, n);
		check(n >= 5 && n <= 25, 1'b1);
	endtask : t_ramp

	task automatic close_out();
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// watchdog well past the expected run length
	initial
	begin
		#200000;
		failures++;
		close_out();
	end

	// mode codes
	// only codes 0 and 2 are ever written to the mode digit
	initial
	begin
		rst_b = 1'b0;
		sel = 16'h0000;
		pc = 1'b1;
		ref_on = 1'b0;
		busy = 1'b0;
		stopped = 1'b1;
		fcfg = 16'h0000;
		tm = '0;
		want = 4'h8;
		for (int i = 0; i < 7; i++)
		begin
			g1[i] = 16'h0100 + 16'(i);
			g2[i] = 16'h0200 + 16'(i);
		end
		t_reset();
		t_filter();
		t_manual();
		t_clamp();
		t_cond();
		t_outside();
		t_ramp();
		close_out();
	end
endmodule : servo_gain_set_switcher_test
